// ==== hw/sli_consts.svh ====
`ifndef SLI_CONSTS_SVH
`define SLI_CONSTS_SVH

// register map, byte addresses
`define SLI_ADDR_W        8
`define SLI_OFS_CTRL      8'h00
`define SLI_OFS_STATUS    8'h04
`define SLI_CTRL_RST      8'h00

// control register fields
`define SLI_CB_USB_CFG    0
`define SLI_CB_FW_FAULT   1
`define SLI_CB_LOW_SUPPLY 2
`define SLI_CB_FW_UPDATE  3
`define SLI_CB_LIN_MODE   4
`define SLI_CB_RUN        5
`define SLI_CB_DEV_ERR    6

// status register fields
`define SLI_SB_LAMPS      0
`define SLI_SB_OVERRUN    6
`define SLI_SB_ERR_PASS   7
`define SLI_SB_RUN        8

// timing
`define SLI_CLK_MHZ       100
`define SLI_SLOW_HALF_MS  500
`define SLI_FAST_HALF_MS  100
`define SLI_FLASH_MS      20
`define SLI_MS_TO_CYC(ms) ((ms) * 1000 * `SLI_CLK_MHZ)
`define SLI_SLOW_HALF_CYC `SLI_MS_TO_CYC(`SLI_SLOW_HALF_MS)
`define SLI_FAST_HALF_CYC `SLI_MS_TO_CYC(`SLI_FAST_HALF_MS)
`define SLI_FLASH_CYC     `SLI_MS_TO_CYC(`SLI_FLASH_MS)

`endif

// ==== hw/sli_pkg.sv ====
package sli_pkg;

	// one lit colour at a time while the running pattern is shown
	typedef enum logic [1:0] {
		RUN_SUP_GREEN,
		RUN_SUP_YELLOW,
		RUN_TRF_YELLOW,
		RUN_TRF_RED
	} sli_run_t;

	typedef struct packed {
		logic [31:0] slow_cnt;
		logic [31:0] fast_cnt;
		logic        slow_ph;
		logic        fast_ph;
		logic [31:0] flash_y;
		logic [31:0] flash_r;
		logic        overrun;
		sli_run_t    run;
		logic [7:0]  ctrl;
		logic [5:0]  lamps;
		logic [31:0] rdata;
	} sli_state_t;

endpackage : sli_pkg

// ==== hw/sli_top.sv ====
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "sli_consts.svh"

// Summary of operation
// R1 - off state drives neither colour
// R2 - flash: one short pulse per event; a new event restarts the pulse, so a burst merges
// R3 - slow blink, equal on and off
// R4 - fast blink, equal halves, faster rate
// R5 - slow waver alternates both colours
// R6 - fast waver alternates colours faster; no pattern here uses a fast waver, both wavers run on the slow phase
// R7 - running: one colour at a time, sequence
// R8 - supply green when configured and healthy
// R9 - unconfigured: supply slow yellow, traffic off
// R10 - faults: waver supply, waver or blink traffic
// R11 - idle channel keeps traffic off
// R12 - CAN message flashes traffic yellow
// R13 - error frame flash red, passive fast red
// R14 - overrun steady red until bus-off
// R15 - firmware update fast-blinks traffic yellow
// R16 - LIN activity flashes traffic yellow
// R17 - info green LIN mode, yellow reference
// R18 - device error lights all traffic red
// R19 - periods and flash width in cycles
module sli_top #(
	parameter int unsigned SLOW_HALF_CYC = `SLI_SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF_CYC = `SLI_FAST_HALF_CYC,
	parameter int unsigned FLASH_CYC     = `SLI_FLASH_CYC
) (
	input  wire logic                   mclk,
	input  wire logic                   reset_n,
	input  wire logic [`SLI_ADDR_W-1:0] addr,
	input  wire logic [31:0]            wdata,
	input  wire logic                   wr_stb,
	input  wire logic                   rd_stb,
	output logic      [31:0]            rdata,
	input  wire logic                   can_msg,
	input  wire logic                   can_err_frame,
	input  wire logic                   can_err_passive,
	input  wire logic                   can_overrun,
	input  wire logic                   can_bus_off,
	input  wire logic                   lin_msg,
	input  wire logic                   lin_activity,
	input  wire logic                   lin_ref_present,
	output logic                        supply_lamp_green,
	output logic                        supply_lamp_yellow,
	output logic                        traffic_lamp_yellow,
	output logic                        traffic_lamp_red,
	output logic                        info_lamp_green,
	output logic                        info_lamp_yellow
);

	sli_pkg::sli_state_t st_q;
	sli_pkg::sli_state_t st_d;

	logic slow_tick;
	logic fast_tick;
	logic c_usb;
	logic c_fwf;
	logic c_low;
	logic c_upd;
	logic c_lin;
	logic c_run;
	logic c_err;
	logic sg;
	logic sy;
	logic ty;
	logic tr;

	function automatic logic [31:0] sat_dec(input logic [31:0] v);
		sat_dec = (v == 32'h0) ? 32'h0 : v - 32'h1;
	endfunction : sat_dec

	function automatic logic [31:0] wrap_inc(input logic [31:0] v, input logic [31:0] lim);
		wrap_inc = (v >= lim - 32'h1) ? 32'h0 : v + 32'h1;
	endfunction : wrap_inc

	always_comb begin
		st_d = st_q;
		c_usb = st_q.ctrl[`SLI_CB_USB_CFG];
		c_fwf = st_q.ctrl[`SLI_CB_FW_FAULT];
		c_low = st_q.ctrl[`SLI_CB_LOW_SUPPLY];
		c_upd = st_q.ctrl[`SLI_CB_FW_UPDATE];
		c_lin = st_q.ctrl[`SLI_CB_LIN_MODE];
		c_run = st_q.ctrl[`SLI_CB_RUN];
		c_err = st_q.ctrl[`SLI_CB_DEV_ERR];

		// phase dividers; each phase flips only at wrap, halves equal
		slow_tick = (st_q.slow_cnt >= SLOW_HALF_CYC - 32'h1);
		fast_tick = (st_q.fast_cnt >= FAST_HALF_CYC - 32'h1);
		st_d.slow_cnt = wrap_inc(st_q.slow_cnt, SLOW_HALF_CYC); // [R19]
		st_d.fast_cnt = wrap_inc(st_q.fast_cnt, FAST_HALF_CYC); // [R19]
		if (slow_tick) begin
			st_d.slow_ph = ~st_q.slow_ph; // [R3]
		end
		if (fast_tick) begin
			// shared by the update blink and the error-passive red blink, so both keep one rate
			st_d.fast_ph = ~st_q.fast_ph; // [R4]
		end

		// a new event restarts the pulse, so a burst merges into steady light
		if ((!c_lin && can_msg) || (c_lin && (lin_msg || lin_activity))) begin
			st_d.flash_y = FLASH_CYC; // [R2] [R12] [R16]
		end else begin
			st_d.flash_y = sat_dec(st_q.flash_y);
		end
		if (!c_lin && can_err_frame) begin
			st_d.flash_r = FLASH_CYC; // [R2] [R13]
		end else begin
			st_d.flash_r = sat_dec(st_q.flash_r);
		end

		// set wins over the bus-off clear
		if (can_overrun && !c_lin) begin
			st_d.overrun = 1'b1; // [R14]
		end else if (can_bus_off) begin
			st_d.overrun = 1'b0; // [R14]
		end

		if (!c_run) begin
			st_d.run = sli_pkg::RUN_SUP_GREEN;
		end else if (slow_tick) begin
			case (st_q.run)
				sli_pkg::RUN_SUP_GREEN: begin
					st_d.run = sli_pkg::RUN_SUP_YELLOW; // [R7]
				end
				sli_pkg::RUN_SUP_YELLOW: begin
					st_d.run = sli_pkg::RUN_TRF_YELLOW; // [R7]
				end
				sli_pkg::RUN_TRF_YELLOW: begin
					st_d.run = sli_pkg::RUN_TRF_RED; // [R7]
				end
				sli_pkg::RUN_TRF_RED: begin
					st_d.run = sli_pkg::RUN_SUP_GREEN; // [R7]
				end
				default: begin
					st_d.run = sli_pkg::RUN_SUP_GREEN;
				end
			endcase
		end

		// lamp decode, highest priority first
		sg = 1'b0; // [R1]
		sy = 1'b0;
		ty = 1'b0;
		tr = 1'b0;
		if (c_run) begin
			sg = (st_q.run == sli_pkg::RUN_SUP_GREEN); // [R7]
			sy = (st_q.run == sli_pkg::RUN_SUP_YELLOW);
			ty = (st_q.run == sli_pkg::RUN_TRF_YELLOW);
			tr = (st_q.run == sli_pkg::RUN_TRF_RED);
		end else if (c_low) begin
			sg = st_q.slow_ph; // [R10] [R5]
			sy = ~st_q.slow_ph;
			ty = st_q.slow_ph; // [R10] [R3]
		end else if (c_fwf) begin
			sg = st_q.slow_ph; // [R10] [R5]
			sy = ~st_q.slow_ph;
			ty = st_q.slow_ph;
			tr = ~st_q.slow_ph;
		end else if (!c_usb) begin
			sy = st_q.slow_ph; // [R9]
		end else begin
			sg = 1'b1; // [R8]
			if (c_err) begin
				tr = 1'b1; // [R18]
			end else if (c_upd) begin
				ty = st_q.fast_ph; // [R15] [R4]
			end else if (c_lin) begin
				ty = (st_q.flash_y != 32'h0); // [R16] [R11]
			end else if (st_q.overrun) begin
				tr = 1'b1; // [R14]
			end else if (can_err_passive) begin
				tr = st_q.fast_ph; // [R13]
			end else if (st_q.flash_r != 32'h0) begin
				tr = 1'b1; // [R13]
			end else begin
				ty = (st_q.flash_y != 32'h0); // [R12] [R11]
			end
		end
		st_d.lamps = {lin_ref_present, c_lin, tr, ty, sy, sg}; // [R17]

		// register port; unmapped reads return zero
		if (wr_stb && addr == `SLI_OFS_CTRL) begin
			st_d.ctrl = {1'b0, wdata[6:0]};
		end
		st_d.rdata = 32'h0;
		if (rd_stb) begin
			case (addr)
				`SLI_OFS_CTRL: begin
					st_d.rdata = {24'h0, st_q.ctrl};
				end
				`SLI_OFS_STATUS: begin
					st_d.rdata[`SLI_SB_LAMPS +: 6]  = st_q.lamps;
					st_d.rdata[`SLI_SB_OVERRUN]     = st_q.overrun;
					st_d.rdata[`SLI_SB_ERR_PASS]    = can_err_passive;
					st_d.rdata[`SLI_SB_RUN +: 2]    = st_q.run;
				end
				default: begin
					st_d.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '{
				slow_cnt: 32'h0,
				fast_cnt: 32'h0,
				slow_ph:  1'b0,
				fast_ph:  1'b0,
				flash_y:  32'h0,
				flash_r:  32'h0,
				overrun:  1'b0,
				run:      sli_pkg::RUN_SUP_GREEN,
				ctrl:     `SLI_CTRL_RST,
				lamps:    6'h0,
				rdata:    32'h0
			};
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata               = st_q.rdata;
	assign supply_lamp_green   = st_q.lamps[0];
	assign supply_lamp_yellow  = st_q.lamps[1];
	assign traffic_lamp_yellow = st_q.lamps[2];
	assign traffic_lamp_red    = st_q.lamps[3];
	assign info_lamp_green     = st_q.lamps[4];
	assign info_lamp_yellow    = st_q.lamps[5];

	// checks
	logic healthy;

	assign healthy = c_usb && !c_run && !c_low && !c_fwf;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	period_order_a: assert property (FAST_HALF_CYC < SLOW_HALF_CYC) // [R19]
		else $error("fast period not shorter than slow");

	slow_halves_a: assert property ( // [R3]
		(st_q.slow_ph != $past(st_q.slow_ph)) |->
			($past(st_q.slow_cnt) == SLOW_HALF_CYC - 32'h1))
		else $error("slow phase flipped off the wrap");

	fast_halves_a: assert property ( // [R4]
		(st_q.fast_ph != $past(st_q.fast_ph)) |->
			($past(st_q.fast_cnt) == FAST_HALF_CYC - 32'h1))
		else $error("fast phase flipped off the wrap");

	unconfigured_a: assert property ( // [R9]
		(!c_usb && !c_run && !c_low && !c_fwf) |=>
			(supply_lamp_yellow == $past(st_q.slow_ph)) && !supply_lamp_green
			&& !traffic_lamp_yellow && !traffic_lamp_red)
		else $error("unconfigured pattern wrong");

	healthy_green_a: assert property ( // [R8]
		healthy |=> supply_lamp_green && !supply_lamp_yellow)
		else $error("supply not steady green");

	fault_waver_a: assert property ( // [R10]
		(c_fwf && !c_low && !c_run) |=>
			(supply_lamp_green != supply_lamp_yellow)
			&& (traffic_lamp_yellow != traffic_lamp_red))
		else $error("fault waver wrong");

	can_flash_a: assert property ( // [R12]
		(healthy && !c_err && !c_upd && !c_lin && can_msg) ##1
		(healthy && !c_err && !c_upd && !c_lin && !st_q.overrun
			&& !can_err_passive && st_q.flash_r == 32'h0)
		|=> traffic_lamp_yellow)
		else $error("message flash missing");

	overrun_hold_a: assert property ( // [R14]
		(st_q.overrun && !can_bus_off) |=> st_q.overrun)
		else $error("overrun latch dropped early");

	overrun_set_a: assert property ( // [R14]
		(can_overrun && !c_lin) |=> st_q.overrun)
		else $error("overrun not latched");

	fw_update_a: assert property ( // [R15]
		(healthy && !c_err && c_upd) |=>
			(traffic_lamp_yellow == $past(st_q.fast_ph)) && !traffic_lamp_red)
		else $error("update blink wrong");

	dev_error_a: assert property ( // [R18]
		(healthy && c_err) |=> traffic_lamp_red && !traffic_lamp_yellow)
		else $error("device error red missing");

	info_lamp_a: assert property ( // [R17]
		##1 (info_lamp_green == $past(c_lin))
			&& (info_lamp_yellow == $past(lin_ref_present)))
		else $error("info lamp mismatch");

	running_one_a: assert property ( // [R7]
		c_run |=> $countones({traffic_lamp_red, traffic_lamp_yellow,
			supply_lamp_yellow, supply_lamp_green}) == 1)
		else $error("running shows more than one colour");

	// retrigger conditions, mirrored so the pulse counters can be checked
	logic y_evt;
	logic r_evt;
	logic can_view;

	assign y_evt    = (!c_lin && can_msg) || (c_lin && (lin_msg || lin_activity));
	assign r_evt    = !c_lin && can_err_frame;
	assign can_view = healthy && !c_err && !c_upd && !c_lin;

	flash_y_load_a: assert property ( // [R2]
		y_evt |=> (st_q.flash_y == FLASH_CYC))
		else $error("yellow pulse not loaded");

	flash_y_run_a: assert property ( // [R2]
		((st_q.flash_y != 32'h0) && !y_evt) |=>
			(st_q.flash_y == $past(st_q.flash_y) - 32'h1))
		else $error("yellow pulse not counting down");

	flash_r_load_a: assert property ( // [R2]
		r_evt |=> (st_q.flash_r == FLASH_CYC))
		else $error("red pulse not loaded");

	flash_r_run_a: assert property ( // [R2]
		((st_q.flash_r != 32'h0) && !r_evt) |=>
			(st_q.flash_r == $past(st_q.flash_r) - 32'h1))
		else $error("red pulse not counting down");

	idle_dark_a: assert property ( // [R11]
		(can_view && !st_q.overrun && !can_err_passive
			&& st_q.flash_r == 32'h0 && st_q.flash_y == 32'h0)
		|=> !traffic_lamp_yellow && !traffic_lamp_red)
		else $error("idle traffic lamp lit");

	passive_red_a: assert property ( // [R13]
		(can_view && !st_q.overrun && can_err_passive) |=>
			(traffic_lamp_red == $past(st_q.fast_ph)) && !traffic_lamp_yellow)
		else $error("error passive blink wrong");

	overrun_red_a: assert property ( // [R14]
		(can_view && st_q.overrun) |=> traffic_lamp_red && !traffic_lamp_yellow)
		else $error("overrun red missing");

	overrun_clear_a: assert property ( // [R14]
		(can_bus_off && !(can_overrun && !c_lin)) |=> !st_q.overrun)
		else $error("bus-off did not clear overrun");

	lin_no_overrun_a: assert property ( // [R16]
		(c_lin && !st_q.overrun) |=> !st_q.overrun)
		else $error("overrun latched in lin mode");

	low_supply_a: assert property ( // [R10] [R5]
		(c_low && !c_run) |=>
			(supply_lamp_green == $past(st_q.slow_ph))
			&& (supply_lamp_yellow == !$past(st_q.slow_ph))
			&& (traffic_lamp_yellow == $past(st_q.slow_ph)) && !traffic_lamp_red)
		else $error("low supply pattern wrong");

	fault_phase_a: assert property ( // [R10] [R5]
		(c_fwf && !c_low && !c_run) |=>
			(supply_lamp_green == $past(st_q.slow_ph))
			&& (traffic_lamp_red == !$past(st_q.slow_ph)))
		else $error("fault waver phase wrong");

	lin_flash_a: assert property ( // [R16]
		(healthy && !c_err && !c_upd && c_lin) |=>
			(traffic_lamp_yellow == ($past(st_q.flash_y) != 32'h0)) && !traffic_lamp_red)
		else $error("lin flash wrong");

	run_hold_a: assert property ( // [R7]
		(c_run && !slow_tick) |=> $stable(st_q.run))
		else $error("running step moved early");

	run_wrap_a: assert property ( // [R7]
		(c_run && slow_tick && st_q.run == sli_pkg::RUN_TRF_RED) |=>
			(st_q.run == sli_pkg::RUN_SUP_GREEN))
		else $error("running sequence did not wrap");

	run_rest_a: assert property ( // [R7]
		!c_run |=> (st_q.run == sli_pkg::RUN_SUP_GREEN))
		else $error("running step not parked");

endmodule : sli_top

// ==== test/sli_led_eye.sv ====
`timescale 1ns/100ps
// operator's eye: lit cycles of each colour since the last clear
module sli_led_eye (
	input  wire logic       mclk,
	input  wire logic       clr,
	input  wire logic [5:0] lamp,
	output int unsigned     on_cnt [6],
	output int unsigned     one_cnt
);
	always @(posedge mclk) begin
		for (int i = 0; i < 6; i++) begin
			on_cnt[i] <= clr ? 0 : on_cnt[i] + lamp[i];
		end
		one_cnt <= clr ? 0 : one_cnt + ($onehot(lamp) ? 1 : 0);
	end
endmodule : sli_led_eye

// ==== test/sli_top_bench.sv ====
`timescale 1ns/100ps
module sli_top_bench;
	logic        mclk    = 1'b0;
	logic        reset_n = 1'b0;
	logic        wr_stb  = 1'b0;
	logic        rd_stb  = 1'b0;
	logic        clr     = 1'b0;
	logic [7:0]  addr    = 8'h00;
	logic [7:0]  ev      = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] rdata;
	logic [31:0] r;
	logic [5:0]  lamp;
	int unsigned on [6];
	int unsigned one_cnt;
	int unsigned n_mismatch = 0;
	int unsigned n_compared = 0;

	always #5 mclk = ~mclk;

	sli_top #(.SLOW_HALF_CYC(40), .FAST_HALF_CYC(8), .FLASH_CYC(4)) uut (
		.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.can_msg(ev[0]), .can_err_frame(ev[1]), .can_err_passive(ev[2]),
		.can_overrun(ev[3]), .can_bus_off(ev[4]), .lin_msg(ev[5]),
		.lin_activity(ev[6]), .lin_ref_present(ev[7]),
		.supply_lamp_green(lamp[0]), .supply_lamp_yellow(lamp[1]),
		.traffic_lamp_yellow(lamp[2]), .traffic_lamp_red(lamp[3]),
		.info_lamp_green(lamp[4]), .info_lamp_yellow(lamp[5])
	);
	sli_led_eye eye (.mclk(mclk), .clr(clr), .lamp(lamp), .on_cnt(on), .one_cnt(one_cnt));

	task report_and_stop;
		$display("mismatches %0d of %0d compares", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got %h want %h", $time, s, e);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
		@(posedge mclk) wr_stb <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the strobe, then 0
	task rd(input logic [7:0] a);
		@(posedge mclk) {addr, rd_stb} <= {a, 1'b1};
		@(posedge mclk) rd_stb <= 1'b0;
		#1 r = rdata;
		@(posedge mclk) #1 chk(rdata, 32'h0);
	endtask : rd

	task w(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : w

	task cl;
		@(posedge mclk) clr <= 1'b1;
		@(posedge mclk) clr <= 1'b0;
	endtask : cl

	task m(input int n);
		cl();
		w(n);
	endtask : m

	task sev(input logic [7:0] v);
		@(posedge mclk) ev <= v;
	endtask : sev

	// flash window: one event, then enough cycles for the pulse to end
	task fl(input logic [7:0] v);
		cl();
		sev(ev | v);
		sev(ev & ~v);
		w(12);
	endtask : fl

	task done(input string s);
		$display("test %s finished", s);
	endtask : done

	initial begin
		#50us;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		rd(8'h00); chk(r, 32'h0);
		wr(8'h00, 32'hffffffff); rd(8'h00); chk(r, 32'h7f);
		wr(8'h08, 32'h1); rd(8'h08); chk(r, 32'h0);
		rd(8'h00); chk(r, 32'h7f);
		wr(8'h00, 32'h0);
		done("registers");
		m(80);
		chk(on[1], 40);
		chk(on[0], 0);
		chk(on[2] + on[3], 0);
		wr(8'h00, 32'h1); m(80);
		chk(on[0], 80);
		chk(on[2] + on[3], 0);
		done("config");
		fl(8'h01); chk(on[2], 4);
		fl(8'h02); chk(on[3], 4);
		sev(8'h04); w(4); m(16);
		chk(on[3], 8);
		sev(8'h08); sev(8'h00); w(4); m(50);
		chk(on[3], 50);
		rd(8'h04); chk(r[6], 1'b1);
		sev(8'h10); w(4); m(16);
		chk(on[3], 0);
		sev(8'h00);
		done("can");
		wr(8'h00, 32'h9); m(16); chk(on[2], 8);
		wr(8'h00, 32'h41); m(16); chk(on[3], 16);
		wr(8'h00, 32'h3); m(80);
		chk(on[0], 40);
		chk(on[1], 40);
		chk(on[2] + on[3], 80);
		wr(8'h00, 32'h5); m(80);
		chk(on[2], 40);
		chk(on[3], 0);
		done("faults");
		wr(8'h00, 32'h11); sev(8'h80); w(4); m(16);
		chk(on[4], 16);
		chk(on[5], 16);
		fl(8'h20); chk(on[2], 4);
		fl(8'h40); chk(on[2], 4);
		fl(8'h01); chk(on[2], 0);
		sev(8'h00);
		done("lin");
		wr(8'h00, 32'h20); w(2); m(160);
		chk(one_cnt, 160);
		chk(on[0], 40);
		chk(on[3], 40);
		done("running");
		report_and_stop();
	end
endmodule : sli_top_bench
